// File: bench/pfc_ctrl_monitor.sv
// pin-level assertions for the parallel fifo controller
`timescale 1ns/1ps
module pfc_ctrl_monitor (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// fifo pins
	input wire logic [pfc_pkg::DATA_W-1:0] din_out,
	input wire logic wr_n_out,
	input wire logic rd_n_out,
	input wire logic fifo_clear_n_out,
	input wire logic rewind_n_out,
	input wire logic full_flag_n_in,
	input wire logic empty_flag_n_in,
	input wire logic depth_exp_in
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	logic seen_q;
	// a clear pulse must have been issued since reset
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			seen_q <= 1'b0;
		end else if (!fifo_clear_n_out) begin
			seen_q <= 1'b1;
		end
	end
	clear_first_a: assert property (!seen_q |-> wr_n_out)
		else $error("write strobe before first clear");
	clear_quiet_a: assert property (!fifo_clear_n_out |-> wr_n_out && rd_n_out)
		else $error("strobe low during clear");
	clear_recover_a: assert property ($rose(fifo_clear_n_out) |-> (wr_n_out && rd_n_out) [*4])
		else $error("strobe too soon after clear");
	// pulses span the launch cycle plus the counted low time, so five samples low
	clear_pulse_a: assert property ($fell(fifo_clear_n_out) |-> (!fifo_clear_n_out) [*5] ##1 fifo_clear_n_out)
		else $error("clear pulse width wrong");
	rewind_quiet_a: assert property (!rewind_n_out |-> wr_n_out && rd_n_out)
		else $error("strobe low during rewind");
	rewind_exp_a: assert property (depth_exp_in [*4] |-> rewind_n_out)
		else $error("rewind in depth expansion");
	write_pulse_a: assert property ($fell(wr_n_out) |-> (!wr_n_out) [*5] ##1 wr_n_out [*2])
		else $error("write strobe shape wrong");
	read_pulse_a: assert property ($fell(rd_n_out) |-> (!rd_n_out) [*5] ##1 rd_n_out [*2])
		else $error("read strobe shape wrong");
	full_block_a: assert property (!full_flag_n_in [*6] |-> !$fell(wr_n_out))
		else $error("write issued while full");
	empty_block_a: assert property (!empty_flag_n_in [*6] |-> !$fell(rd_n_out))
		else $error("read issued while empty");
	data_hold_a: assert property ($fell(wr_n_out) |=> $stable(din_out) [*4])
		else $error("write data moved in strobe");
	cover property ($fell(wr_n_out));
	// the model lifts full as the strobe falls, so look one sample back
	cover property ($fell(rd_n_out) && !$past(full_flag_n_in));
	cover property ($fell(rewind_n_out));
endmodule // pfc_ctrl_monitor
bind pfc_ctrl pfc_ctrl_monitor mon_u (.sys_clk_in, .resetn_in, .din_out, .wr_n_out, .rd_n_out,
	.fifo_clear_n_out, .rewind_n_out, .full_flag_n_in, .empty_flag_n_in, .depth_exp_in);

// File: bench/pfc_fifo_model.sv
// behavioural model of the parallel fifo device at its pins
`timescale 1ns/1ps
module pfc_fifo_model #(
	parameter int DEPTH = 16
) (
	// strobes and control
	input wire logic wr_n_in,
	input wire logic rd_n_in,
	input wire logic fifo_clear_n_in,
	input wire logic rewind_n_in,
	// data
	input wire logic [8:0] din_in,
	output logic [8:0] dout_out,
	// flags
	output logic full_flag_n_out,
	output logic empty_flag_n_out,
	output logic half_full_flag_n_out
);
	logic [8:0] mem [DEPTH];
	logic [8:0] last = 9'h000;
	logic wok = 1'b0;
	logic rok = 1'b0;
	int w = 0;
	int r = 0;
	int slot = 0;
	assign full_flag_n_out = (w - r) != DEPTH;
	assign empty_flag_n_out = w != r;
	assign half_full_flag_n_out = (w - r) <= DEPTH / 2;
	// released bus shows inverse, not held data
	assign dout_out = (!rd_n_in && rok) ? last : ~last;
	always @(negedge fifo_clear_n_in) begin
		w = 0;
		r = 0;
	end
	always @(negedge wr_n_in) begin
		wok = fifo_clear_n_in && full_flag_n_out;
		if (wok) begin
			slot = w % DEPTH;
			w++;
		end
	end
	always @(posedge wr_n_in) if (wok) mem[slot] = din_in;
	always @(negedge rd_n_in) begin
		rok = empty_flag_n_out;
		if (rok) begin
			last = mem[r % DEPTH];
			r++;
		end
	end
	always @(negedge rewind_n_in) r = 0;
endmodule // pfc_fifo_model

// File: bench/tb_pfc_ctrl.sv
// self-checking bench for the parallel fifo controller
`timescale 1ns/1ps
module tb_pfc_ctrl;
	localparam int DEP = 16;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, dexp = 0;
	logic pready, pslverr, err, rv = 0, rf = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [8:0] din, dout;
	logic wr_n, rd_n, clr_n, rw_n, full_n, empty_n, half_n;
	int mismatches = 0, cmp_count = 0, cyc = 0, seed = 69, ridx = 0, n;
	int hist[$];
	pfc_ctrl #(.DEPTH(DEP)) dut_u (.sys_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .din_out(din), .dout_in(dout), .wr_n_out(wr_n), .rd_n_out(rd_n),
		.fifo_clear_n_out(clr_n), .rewind_n_out(rw_n), .full_flag_n_in(full_n), .empty_flag_n_in(empty_n),
		.half_full_flag_n_in(half_n), .depth_exp_in(dexp));
	pfc_fifo_model #(.DEPTH(DEP)) model_u (.wr_n_in(wr_n), .rd_n_in(rd_n), .fifo_clear_n_in(clr_n),
		.rewind_n_in(rw_n), .din_in(din), .dout_out(dout), .full_flag_n_out(full_n),
		.empty_flag_n_out(empty_n), .half_full_flag_n_out(half_n));
	always #5 clk = ~clk;
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard, far beyond the thousand or so cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic poll;
		do apb(1'b0, pfc_pkg::REG_STATUS, 32'h0); while (q[pfc_pkg::ST_BUSY_BIT] !== 1'b0);
	endtask
	task automatic stchk;
		logic [7:0] e;
		n = hist.size() - ridx;
		e = 8'h02;
		e[pfc_pkg::ST_EMPTY_BIT] = n == 0;
		e[pfc_pkg::ST_FULL_BIT] = n == DEP;
		e[pfc_pkg::ST_HALF_BIT] = n > DEP / 2;
		e[pfc_pkg::ST_RVALID_BIT] = rv;
		e[pfc_pkg::ST_REFUSED_BIT] = rf;
		e[pfc_pkg::ST_DEPTH_EXP_BIT] = dexp;
		apb(1'b0, pfc_pkg::REG_STATUS, 32'h0);
		chk(q & 32'h0000_00ff, {24'h0, e});
	endtask
	task automatic wop;
		logic [31:0] d;
		d = $random(seed);
		apb(1'b1, pfc_pkg::REG_WDATA, d);
		poll;
		if (hist.size() - ridx < DEP) hist.push_back(d & 32'h1ff);
		else rf = 1'b1;
		stchk;
	endtask
	task automatic ctl(input logic [31:0] c);
		apb(1'b1, pfc_pkg::REG_CTRL, c);
		poll;
		rf = 1'b0;
		if (c == 32'h1) begin
			hist.delete();
			ridx = 0;
		end else if (c == 32'h2) begin
			if (dexp) rf = 1'b1;
			else ridx = 0;
		end else if (hist.size() > ridx) begin
			ridx++;
			rv = 1'b1;
		end else rf = 1'b1;
		stchk;
		if (rv) begin
			apb(1'b0, pfc_pkg::REG_RDATA, 32'h0);
			chk(q & 32'h1ff, hist[ridx-1]);
			rv = 1'b0;
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, pfc_pkg::REG_STATUS, 32'h0);
		chk(q & 32'h2, 32'h0);
		apb(1'b1, pfc_pkg::REG_WDATA, 32'h1ff);
		ctl(32'h1);
		ctl(32'h4);
		repeat (DEP + 1) wop;
		apb(1'b0, pfc_pkg::REG_COUNT, 32'h0);
		chk(q, hist.size());
		repeat (9) ctl(32'h4);
		ctl(32'h2);
		repeat (DEP + 1) ctl(32'h4);
		dexp <= 1'b1;
		repeat (4) @(posedge clk);
		ctl(32'h2);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
		conclude;
	end
endmodule // tb_pfc_ctrl

// File: rtl/pfc_cmd_if.sv
// command carrier between the bus slave and the pin sequencer
`timescale 1ns/1ps
interface pfc_cmd_if;
	logic req;
	pfc_pkg::pfc_op_t op;
	logic [pfc_pkg::DATA_W-1:0] wdata;
	logic busy;
	logic done;
	logic refused;
	logic [pfc_pkg::DATA_W-1:0] rdata;
	modport master (output req, output op, output wdata, input busy, input done, input refused, input rdata);
	modport seq (input req, input op, input wdata, output busy, output done, output refused, output rdata);
endinterface

// File: rtl/pfc_ctrl.sv
// apb controller that operates an external parallel fifo through its pins
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module pfc_ctrl #(
	parameter int DATA_W = pfc_pkg::DATA_W,
	parameter int DEPTH = pfc_pkg::DEPTH
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// fifo pins
	output logic [DATA_W-1:0] din_out,
	input wire logic [DATA_W-1:0] dout_in,
	output logic wr_n_out,
	output logic rd_n_out,
	output logic fifo_clear_n_out,
	output logic rewind_n_out,
	input wire logic full_flag_n_in,
	input wire logic empty_flag_n_in,
	input wire logic half_full_flag_n_in,
	// strap: high when the fifo is wired for depth expansion
	input wire logic depth_exp_in
);
	pfc_cmd_if cmd ();
	logic [2:0] flag_m_q;
	logic [2:0] flag_s_q;
	logic [DATA_W-1:0] dout_m_q;
	logic [DATA_W-1:0] dout_s_q;
	logic dexp_m_q;
	logic dexp_s_q;
	logic cleared;
	logic req_q;
	pfc_pkg::pfc_op_t op_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic rvalid_q;
	logic refused_q;
	logic [12:0] wcount_q;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic busy_all;

	// all pin inputs pass two flops; the fifo answers on its own timing
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flag_m_q <= 3'h0;
			flag_s_q <= 3'h0;
			dout_m_q <= '0;
			dout_s_q <= '0;
			dexp_m_q <= 1'b0;
			dexp_s_q <= 1'b0;
		end else begin
			flag_m_q <= {half_full_flag_n_in, full_flag_n_in, empty_flag_n_in};
			flag_s_q <= flag_m_q;
			dout_m_q <= dout_in;
			dout_s_q <= dout_m_q;
			dexp_m_q <= depth_exp_in;
			dexp_s_q <= dexp_m_q;
		end
	end

	pfc_pin_seq u_seq (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.cmd(cmd.seq),
		.full_n_s_in(flag_s_q[1]),
		.empty_n_s_in(flag_s_q[0]),
		.depth_exp_in(dexp_s_q),
		.dout_s_in(dout_s_q),
		.wr_n_out(wr_n_out),
		.rd_n_out(rd_n_out),
		.fifo_clear_n_out(fifo_clear_n_out),
		.rewind_n_out(rewind_n_out),
		.din_out(din_out),
		.cleared_out(cleared)
	);

	assign acc = psel_in && penable_in;
	assign pready_out = 1'b1;
	assign wr_acc = acc && pwrite_in;
	assign rd_acc = acc && !pwrite_in;
	assign busy_all = req_q || cmd.busy;
	assign cmd.req = req_q;
	assign cmd.op = op_q;
	assign cmd.wdata = wdata_q;

	// unmapped addresses answer with an error
	always_comb begin
		case (paddr_in)
			pfc_pkg::REG_CTRL, pfc_pkg::REG_STATUS, pfc_pkg::REG_WDATA,
			pfc_pkg::REG_RDATA, pfc_pkg::REG_COUNT: pslverr_out = 1'b0;
			default: pslverr_out = acc;
		endcase
	end

	// one command at a time; writes are dropped while busy or before the first clear
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			req_q <= 1'b0;
			op_q <= pfc_pkg::PFC_OP_WRITE;
			wdata_q <= '0;
		end else if (req_q) begin
			req_q <= 1'b0;
		end else if (wr_acc && !cmd.busy) begin
			if (paddr_in == pfc_pkg::REG_CTRL) begin
				req_q <= |pwdata_in[2:0];
				if (pwdata_in[pfc_pkg::CTRL_CLEAR_BIT]) begin
					op_q <= pfc_pkg::PFC_OP_CLEAR;
				end else if (pwdata_in[pfc_pkg::CTRL_REWIND_BIT]) begin
					op_q <= pfc_pkg::PFC_OP_REWIND;
				end else begin
					op_q <= pfc_pkg::PFC_OP_READ;
				end
			end else if (paddr_in == pfc_pkg::REG_WDATA && cleared) begin
				req_q <= 1'b1;
				op_q <= pfc_pkg::PFC_OP_WRITE;
				wdata_q <= pwdata_in[DATA_W-1:0];
			end
		end
	end

	// read word and valid bit; valid clears on reading the data register, set wins
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end else if (cmd.done && !cmd.refused && op_q == pfc_pkg::PFC_OP_READ) begin
			rdata_q <= cmd.rdata;
			rvalid_q <= 1'b1;
		end else if (rd_acc && paddr_in == pfc_pkg::REG_RDATA) begin
			rvalid_q <= 1'b0;
		end
	end

	// sticky refusal, cleared by a control write; a new refusal wins
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			refused_q <= 1'b0;
		end else if (cmd.refused) begin
			refused_q <= 1'b1;
		end else if (wr_acc && paddr_in == pfc_pkg::REG_CTRL) begin
			refused_q <= 1'b0;
		end
	end

	// writes since clear counted for rewind
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wcount_q <= '0;
		end else if (cmd.done && !cmd.refused) begin
			if (op_q == pfc_pkg::PFC_OP_CLEAR) begin
				wcount_q <= '0;
			end else if (op_q == pfc_pkg::PFC_OP_WRITE && wcount_q != 13'h1fff) begin
				wcount_q <= wcount_q + 13'h0001;
			end
		end
	end

	// flags shown only after clear recovery
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prdata_out <= pfc_pkg::RDATA_RESET;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			case (paddr_in)
				pfc_pkg::REG_STATUS: prdata_out <= {24'h000000, dexp_s_q, refused_q, rvalid_q,
					cleared && !flag_s_q[2], cleared && !flag_s_q[1],
					cleared && !flag_s_q[0], cleared && !busy_all, busy_all};
				pfc_pkg::REG_RDATA: prdata_out <= {{(32 - DATA_W){1'b0}}, rdata_q};
				pfc_pkg::REG_COUNT: prdata_out <= {19'h00000, wcount_q};
				default: prdata_out <= 32'h0000_0000;
			endcase
		end
	end
endmodule // pfc_ctrl

// File: rtl/pfc_pin_seq.sv
// pin sequencer that drives the fifo strobes, clear and rewind pins
`timescale 1ns/1ps
module pfc_pin_seq (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// command side
	pfc_cmd_if.seq cmd,
	// flags, already synchronised
	input wire logic full_n_s_in,
	input wire logic empty_n_s_in,
	input wire logic depth_exp_in,
	input wire logic [pfc_pkg::DATA_W-1:0] dout_s_in,
	// pins
	output logic wr_n_out,
	output logic rd_n_out,
	output logic fifo_clear_n_out,
	output logic rewind_n_out,
	output logic [pfc_pkg::DATA_W-1:0] din_out,
	output logic cleared_out
);
	typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_RECOVER} pfc_seq_t;
	pfc_seq_t st_q;
	pfc_pkg::pfc_op_t op_q;
	logic [pfc_pkg::CNT_W-1:0] cnt_q;
	logic take;
	logic ok;

	function automatic logic [pfc_pkg::CNT_W-1:0] cyc(input int n);
		cyc = pfc_pkg::CNT_W'(n - 1);
	endfunction

	// a write needs full high, a read needs empty high; rewind barred in depth expansion
	always_comb begin
		case (cmd.op)
			pfc_pkg::PFC_OP_WRITE: ok = full_n_s_in;
			pfc_pkg::PFC_OP_READ: ok = empty_n_s_in;
			pfc_pkg::PFC_OP_REWIND: ok = !depth_exp_in;
			default: ok = 1'b1;
		endcase
	end
	assign take = (st_q == S_IDLE) && cmd.req;
	assign cmd.busy = (st_q != S_IDLE);

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= S_IDLE;
			op_q <= pfc_pkg::PFC_OP_WRITE;
			cnt_q <= '0;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (take && ok) begin
						st_q <= S_LOW;
						op_q <= cmd.op;
						cnt_q <= (cmd.op == pfc_pkg::PFC_OP_CLEAR) ? cyc(pfc_pkg::RESET_LOW_CYC)
							: cyc(pfc_pkg::STROBE_LOW_CYC);
					end
				end
				S_LOW: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
					end else begin
						st_q <= S_HIGH;
						cnt_q <= (op_q == pfc_pkg::PFC_OP_CLEAR) ? cyc(pfc_pkg::RESET_RECOVER_CYC)
							: cyc(pfc_pkg::STROBE_HIGH_CYC);
					end
				end
				S_HIGH: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
					end else begin
						st_q <= S_RECOVER;
						cnt_q <= cyc(pfc_pkg::SAMPLE_CYC);
					end
				end
				S_RECOVER: begin
					// flags settle after the strobe; wait before trusting them
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
					end else begin
						st_q <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_n_out <= 1'b1;
			rd_n_out <= 1'b1;
			fifo_clear_n_out <= 1'b1;
			rewind_n_out <= 1'b1;
		end else begin
			wr_n_out <= !(st_q == S_LOW && op_q == pfc_pkg::PFC_OP_WRITE) && !(take && ok && cmd.op == pfc_pkg::PFC_OP_WRITE);
			rd_n_out <= !(st_q == S_LOW && op_q == pfc_pkg::PFC_OP_READ) && !(take && ok && cmd.op == pfc_pkg::PFC_OP_READ);
			fifo_clear_n_out <= !(st_q == S_LOW && op_q == pfc_pkg::PFC_OP_CLEAR) && !(take && cmd.op == pfc_pkg::PFC_OP_CLEAR);
			rewind_n_out <= !(st_q == S_LOW && op_q == pfc_pkg::PFC_OP_REWIND) && !(take && ok && cmd.op == pfc_pkg::PFC_OP_REWIND);
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			din_out <= '0;
		end else if (take && cmd.op == pfc_pkg::PFC_OP_WRITE) begin
			din_out <= cmd.wdata;
		end
	end

	// read data sampled at the last low cycle, before the outputs float
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd.rdata <= '0;
		end else if (st_q == S_LOW && op_q == pfc_pkg::PFC_OP_READ && cnt_q == '0) begin
			cmd.rdata <= dout_s_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cleared_out <= 1'b0;
		end else if (st_q == S_RECOVER && op_q == pfc_pkg::PFC_OP_CLEAR && cnt_q == '0) begin
			cleared_out <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd.done <= 1'b0;
			cmd.refused <= 1'b0;
		end else begin
			cmd.done <= (st_q == S_RECOVER && cnt_q == '0) || (take && !ok);
			cmd.refused <= take && !ok;
		end
	end
endmodule // pfc_pin_seq

// File: rtl/pfc_pkg.sv
// package of constants for the parallel fifo controller
package pfc_pkg;
	localparam int DATA_W = 9;
	localparam int DEPTH = 4096;
	localparam int CLK_MHZ = 100;
	// strobe timing in ns, converted to cycles (least times round up)
	localparam int T_STROBE_LOW_NS = 40;
	localparam int T_STROBE_HIGH_NS = 20;
	localparam int T_RESET_LOW_NS = 40;
	localparam int T_RESET_RECOVER_NS = 40;
	localparam int T_SAMPLE_NS = 30;
	localparam int STROBE_LOW_CYC = (T_STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_HIGH_CYC = (T_STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_LOW_CYC = (T_RESET_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_RECOVER_CYC = (T_RESET_RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int SAMPLE_CYC = (T_SAMPLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 8;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_COUNT = 8'h10;
	// control field positions (write 1 to start a command)
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_REWIND_BIT = 1;
	localparam int CTRL_READ_BIT = 2;
	// status field positions
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_EMPTY_BIT = 2;
	localparam int ST_FULL_BIT = 3;
	localparam int ST_HALF_BIT = 4;
	localparam int ST_RVALID_BIT = 5;
	localparam int ST_REFUSED_BIT = 6;
	localparam int ST_DEPTH_EXP_BIT = 7;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {PFC_OP_WRITE, PFC_OP_READ, PFC_OP_REWIND, PFC_OP_CLEAR} pfc_op_t;
endpackage
